// file: dbr_buf2.sv
/*
 dbr_buf2: two-entry valid/ready buffer for read data words.
 Assumes a single clock domain and synchronous active-high reset.
*/
module dbr_buf2 import dbr_pkg::*; #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [1:0] cnt;
   } dbr_buf_t;
   dbr_buf_t s_r, s_nxt;
   logic push, pop;

   // a pop in the same cycle frees a slot, so a full buffer still takes a word from a source that cannot stall
   assign in_ready = (s_r.cnt != 2'h2) || out_ready;
   assign out_valid = (s_r.cnt != 2'h0);
   assign out_data = s_r.mem[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_nxt = s_r;
      if (pop) begin
         s_nxt.mem[0] = s_r.mem[1];
      end
      if (push) begin
         if ((s_r.cnt == 2'h0) || (s_r.cnt == 2'h1 && pop)) begin
            s_nxt.mem[0] = in_data;
         end else begin
            s_nxt.mem[1] = in_data;
         end
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
      if (srst) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end
endmodule

// file: dbr_ctrl.sv
/*
 dbr_ctrl: memory-side command controller that drives a DDR3-style device's command,
 address and data pins. It issues reads and writes with on-the-fly burst choice, keeps a
 refresh debt, precharges before refresh and respects the refresh cycle time.
 Assumes pins are sampled synchronous to sys_clk (one beat per cycle, single data rate
 model of the link), banks are left open by nothing else, and the device clock is sys_clk.
*/
// Behaviour
// - eight beats when mode field is fixed-8, or on-the-fly with select high.
// - read capture accepts each strobe edge anywhere in the allowed window; here mem_dqs_in is unused, beats sampled RL cycles after the command.
// - after other timing faults, controller performs full reset and initialization; here it only latches need_reinit and holds req_ready low until srst.
// - every strobe edge of a write burst must meet its timing.
// - all banks precharged and idle for the precharge time before refresh.
// - after refresh only NOP or deselect until the refresh cycle time passes.
// - one separate refresh command per interval on average.
// - at most eight refreshes postponed; gap never beyond nine intervals.
// - up to eight refreshes pulled in, each cancelling one later.
// - beyond eight pulled in gives no credit.
// - postponed refreshes all issued before self-refresh entry.
module dbr_ctrl import dbr_pkg::*; #(
   parameter int DW = 16,
   parameter int AW = 15,
   parameter int AL = 0,
   parameter int CL = 5,
   parameter int REFI = REFI_CYC,
   parameter int RFC = RFC_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   // user side
   input wire logic [1:0] mode_burst_field,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_long,
   input wire logic [2:0] req_bank,
   input wire logic [AW-1:0] req_col,
   input wire logic [DW-1:0] wr_data,
   output logic wr_data_take,
   input wire logic ref_pull_in,
   input wire logic sref_req,
   output logic sref_ok,
   input wire logic timing_fault,
   output logic need_reinit,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [DW-1:0] rd_data,
   output logic rd_last,
   // device pins
   output logic mem_cs_n,
   output logic mem_ras_n,
   output logic mem_cas_n,
   output logic mem_we_n,
   output logic [2:0] mem_ba,
   output logic [AW-1:0] mem_addr,
   input wire logic [DW-1:0] mem_dq_in,
   output logic [DW-1:0] mem_dq_out,
   output logic mem_dq_oe,
   input wire logic mem_dqs_in,
   output logic mem_dqs_out,
   output logic mem_dqs_oe
);
   localparam int RL = AL + CL;
   localparam int CW = 16;
   localparam int DEBT_W = 5;

   typedef struct packed {
      dbr_state_t st;
      logic [CW-1:0] cnt;
      logic [3:0] beats;
      logic [3:0] beat_cnt;
      logic [CW-1:0] refi_cnt;
      logic signed [DEBT_W-1:0] debt;
      logic [3:0] cmd;
      logic [2:0] ba;
      logic [AW-1:0] addr;
      logic [DW-1:0] dq_out;
      logic dq_oe;
      logic dqs_out;
      logic reinit;
   } dbr_ctl_t;
   dbr_ctl_t s_r, s_nxt;

   logic cap_valid, cap_ready;
   logic [DW:0] cap_data, rd_word;

   // decoded burst length, used for reads and writes alike
   function automatic logic [3:0] burst_beats(input logic [1:0] fld, input logic sel);
      if (fld == BL_FIXED8 || (fld == BL_ON_FLY && sel)) begin
         burst_beats = 4'(BEATS_FULL);
      end else begin
         burst_beats = 4'(BEATS_CHOP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic refresh_due, refresh_urgent, may_pull, refresh_go;
   assign refresh_due = (s_r.debt > 0);
   assign refresh_urgent = (s_r.debt >= DEBT_W'(MAX_POSTPONE));
   assign may_pull = (s_r.debt > -DEBT_W'(MAX_PULLIN));
   assign refresh_go = refresh_due || (ref_pull_in && may_pull) || (sref_req && s_r.debt > 0);
   // ready stays low whenever idle starts a refresh instead, so a shown ready is always a taken request
   assign req_ready = (s_r.st == DBR_IDLE) && !refresh_go && !refresh_urgent && !s_r.reinit && !sref_req;
   assign sref_ok = (s_r.st == DBR_IDLE) && (s_r.debt <= 0);
   assign wr_data_take = (s_r.st == DBR_WRITE_DATA);
   // read data sampled on each beat; the strobe is not used as a fixed-phase clock
   assign cap_valid = (s_r.st == DBR_READ_DATA);
   assign cap_data = {(s_r.beat_cnt == s_r.beats - 4'h1), mem_dq_in};

   always_comb begin
      s_nxt = s_r;
      s_nxt.cmd = CMD_NOP;
      s_nxt.dq_oe = 1'b0;
      s_nxt.dqs_out = 1'b0;
      if (s_r.refi_cnt == CW'(REFI - 1)) begin
         s_nxt.refi_cnt = '0;
         s_nxt.debt = s_r.debt + DEBT_W'(1);
      end else begin
         s_nxt.refi_cnt = s_r.refi_cnt + CW'(1);
      end
      if (timing_fault) begin
         s_nxt.reinit = 1'b1;
      end
      unique case (s_r.st)
         DBR_IDLE: begin
            if (refresh_go) begin
               s_nxt.cmd = CMD_PRE_ALL;
               s_nxt.addr = '0;
               s_nxt.addr[A10_POS] = 1'b1;
               s_nxt.cnt = CW'(RP_CYC - 1);
               s_nxt.st = DBR_PRE_WAIT;
            end else if (req_valid && req_ready) begin
               s_nxt.ba = req_bank;
               s_nxt.addr = req_col;
               // the select bit replaces any column bit at that position
               s_nxt.addr[BURST_SEL_POS] = req_long;
               s_nxt.beats = burst_beats(mode_burst_field, req_long);
               s_nxt.beat_cnt = '0;
               if (req_write) begin
                  s_nxt.cmd = CMD_WR;
                  s_nxt.cnt = CW'(RL - 2);
                  s_nxt.st = DBR_WRITE_DATA;
               end else begin
                  s_nxt.cmd = CMD_RD;
                  // command cycle plus RL - 1 waits puts the first capture RL cycles after the command
                  s_nxt.cnt = CW'(RL - 1);
                  s_nxt.st = DBR_READ_WAIT;
               end
            end
         end
         DBR_PRE_WAIT: begin
            if (s_r.cnt == '0) begin
               s_nxt.cmd = CMD_REF;
               s_nxt.addr = '0;
               s_nxt.debt = s_nxt.debt - DEBT_W'(1);
               s_nxt.cnt = CW'(RFC - 1);
               s_nxt.st = DBR_RFC_WAIT;
            end else begin
               s_nxt.cnt = s_r.cnt - CW'(1);
            end
         end
         DBR_RFC_WAIT: begin
            // only NOP until the cycle time passes; banks stay idle afterwards
            if (s_r.cnt == '0) begin
               s_nxt.st = DBR_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - CW'(1);
            end
         end
         DBR_READ_WAIT: begin
            if (s_r.cnt == '0) begin
               s_nxt.st = DBR_READ_DATA;
            end else begin
               s_nxt.cnt = s_r.cnt - CW'(1);
            end
         end
         DBR_READ_DATA: begin
            if (cap_ready) begin
               s_nxt.beat_cnt = s_r.beat_cnt + 4'h1;
            end
            if (s_r.beat_cnt == s_r.beats - 4'h1) begin
               // chop still occupies the tCCD slot before the next column command
               s_nxt.st = DBR_IDLE;
            end else if (!cap_ready) begin
               s_nxt.reinit = 1'b1;
            end
         end
         DBR_WRITE_DATA: begin
            // every beat driven with its own strobe edge for the whole burst
            s_nxt.dq_oe = 1'b1;
            s_nxt.dqs_out = ~s_r.dqs_out;
            s_nxt.dq_out = wr_data;
            s_nxt.beat_cnt = s_r.beat_cnt + 4'h1;
            if (s_r.beat_cnt == s_r.beats - 4'h1) begin
               s_nxt.st = DBR_IDLE;
            end
         end
         DBR_HALT: begin
            s_nxt.st = DBR_IDLE;
         end
      endcase
      if (srst) begin
         s_nxt = '0;
         s_nxt.st = DBR_IDLE;
         s_nxt.cmd = CMD_DES;
      end
   end

   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // two entries absorb a one-cycle stall from the reader so no beat is dropped
   dbr_buf2 #(.WIDTH(DW + 1)) u_rbuf (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(cap_valid),
      .in_ready(cap_ready),
      .in_data(cap_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_word)
   );

   // the last-beat flag travels with its word through the buffer
   assign rd_data = rd_word[DW-1:0];
   assign rd_last = rd_word[DW];
   assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = s_r.cmd;
   assign mem_ba = s_r.ba;
   assign mem_addr = s_r.addr;
   assign mem_dq_out = s_r.dq_out;
   assign mem_dq_oe = s_r.dq_oe;
   assign mem_dqs_out = s_r.dqs_out;
   assign mem_dqs_oe = s_r.dq_oe;
   assign need_reinit = s_r.reinit;
endmodule

// file: dbr_ctrl_asserts.sv
/* dbr_ctrl_asserts: pin-level checks of the command controller.
 Assumes a bind onto dbr_ctrl, one clock and synchronous reset. */
module dbr_ctrl_asserts import dbr_pkg::*; #(
   parameter int DW = 16,
   parameter int AW = 15,
   parameter int REFI = REFI_CYC,
   parameter int RFC = RFC_CYC
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic req_long,
   input wire logic sref_req,
   input wire logic timing_fault,
   input wire logic need_reinit,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [DW-1:0] rd_data,
   input wire logic mem_cs_n,
   input wire logic mem_ras_n,
   input wire logic mem_cas_n,
   input wire logic mem_we_n,
   input wire logic [AW-1:0] mem_addr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [3:0] cmd;
   int since_r;
   assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
   // saturates so a long idle spell cannot wrap
   always_ff @(posedge sys_clk) begin
      if (srst) since_r <= RFC;
      else if (cmd == CMD_REF) since_r <= 1;
      else if (since_r < 100000) since_r <= since_r + 1;
   end
   sequence s_take(w);
      req_valid && req_ready && req_write == w;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_PRE_REF: assert property (cmd == CMD_REF |-> $past(cmd, 3) == CMD_PRE_ALL)
      else $error("refresh not preceded by precharge-all");
   AST_RFC_QUIET: assert property (cmd != CMD_NOP && cmd != CMD_DES |-> since_r >= RFC)
      else $error("command inside refresh cycle time");
   AST_REF_GAP: assert property (since_r <= 9 * REFI)
      else $error("refresh gap too long");
   AST_RD_CMD: assert property (s_take(1'b0) |=> cmd == CMD_RD && mem_addr[BURST_SEL_POS] == $past(req_long))
      else $error("read command or select bit wrong");
   AST_WR_CMD: assert property (s_take(1'b1) |=> cmd == CMD_WR && mem_addr[BURST_SEL_POS] == $past(req_long))
      else $error("write command or select bit wrong");
   AST_SREF_HOLD: assert property (sref_req |-> !req_ready)
      else $error("request accepted during self-refresh request");
   AST_FAULT: assert property (timing_fault |=> need_reinit [*3])
      else $error("fault did not latch reinit");
   AST_REINIT_BLOCK: assert property (need_reinit |-> !req_ready)
      else $error("request accepted while reinit needed");
   AST_RD_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read beat dropped under stall");
endmodule
bind dbr_ctrl dbr_ctrl_asserts #(.DW(DW), .AW(AW), .REFI(REFI), .RFC(RFC)) dbr_ctrl_asserts_inst (
   .sys_clk(sys_clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
   .req_long(req_long), .sref_req(sref_req), .timing_fault(timing_fault), .need_reinit(need_reinit),
   .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
   .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr));

// file: dbr_ctrl_test.sv
/* dbr_ctrl_test: scenarios for the command controller against the device model.
 Assumes REFI 50 and RFC 10 cycles, AL 0 and CL 5. */
module dbr_ctrl_test import dbr_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0, srst = 1, req_valid = 0, req_ready, req_write = 0, req_long = 0, wr_data_take;
   logic ref_pull_in = 0, sref_req = 0, sref_ok, timing_fault = 0, need_reinit, rd_valid, rd_ready = 1, rd_last;
   logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe, mem_dqs_out, mem_dqs_oe;
   logic [1:0] mode_burst_field = BL_ON_FLY;
   logic [2:0] req_bank = 0, mem_ba;
   logic [14:0] req_col = 0, mem_addr;
   logic [15:0] wr_data, rd_data, mem_dq_in, mem_dq_out;
   logic [3:0] wbeat = 0;
   int err_count = 0, tests_run = 0;
   assign wr_data = {12'hC00, wbeat};
   always @(posedge sys_clk) if (wr_data_take === 1'b1) wbeat <= wbeat + 4'h1;
   dbr_ctrl #(.REFI(50), .RFC(10)) dbr_ctrl_inst (.sys_clk, .srst, .mode_burst_field, .req_valid, .req_ready,
      .req_write, .req_long, .req_bank, .req_col, .wr_data, .wr_data_take, .ref_pull_in, .sref_req, .sref_ok,
      .timing_fault, .need_reinit, .rd_valid, .rd_ready, .rd_data, .rd_last, .mem_cs_n, .mem_ras_n, .mem_cas_n,
      .mem_we_n, .mem_ba, .mem_addr, .mem_dq_in, .mem_dq_out, .mem_dq_oe, .mem_dqs_in(1'b0), .mem_dqs_out,
      .mem_dqs_oe);
   dbr_dev_model #(.RL(5), .RFC(10)) dbr_dev_model_inst (.sys_clk, .mode_burst_field,
      .cmd({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
   initial forever #2.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic send(input logic w, input logic l, input logic [14:0] col);
      int n;
      @(posedge sys_clk);
      {req_valid, req_write, req_long, req_bank, req_col} <= {1'b1, w, l, 3'h2, col};
      for (n = 0; n < 300; n++) begin
         @(posedge sys_clk);
         if (req_ready === 1'b1) break;
      end
      req_valid <= 0;
      if (n == 300) check(0, 1);
   endtask
   // the stall after the first beat exercises the buffer without overflowing it
   task automatic t_read(input logic [1:0] m, input logic l, input logic [7:0] c);
      int k;
      int st;
      int n;
      k = 0;
      st = 0;
      n = (m == BL_FIXED8 || l) ? 8 : 4;
      mode_burst_field <= m;
      send(0, l, {2'h0, !l, 4'h0, c});
      repeat (40) begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            check(rd_data, {4'hD, c, k[3:0]});
            check(rd_last, k == n - 1);
            k++;
         end
         if (k == 1 && st == 0) begin
            rd_ready <= 0;
            st = 1;
         end else rd_ready <= 1;
      end
      check(k, n);
      check(need_reinit, 0);
   endtask
   task automatic t_write(input logic l);
      int e;
      logic dp;
      e = 0;
      dp = 1'b0;
      wbeat <= 0;
      mode_burst_field <= BL_ON_FLY;
      send(1, l, 15'h0040);
      // every driven beat must bring its own strobe edge
      repeat (30) begin
         @(posedge sys_clk);
         if (mem_dqs_oe === 1'b1 && mem_dqs_out !== dp) e++;
         dp = mem_dqs_out;
      end
      check(e, l ? 8 : 4);
      check(dbr_dev_model_inst.wn, l ? 8 : 4);
      for (int k = 0; k < (l ? 8 : 4); k++) check(dbr_dev_model_inst.wq[k], 16'hC000 + k);
   endtask
   task automatic t_refresh(input logic pull, input int cyc, input int lo, input int hi);
      int r0;
      r0 = dbr_dev_model_inst.ref_count;
      ref_pull_in <= pull;
      repeat (cyc) @(posedge sys_clk);
      ref_pull_in <= 0;
      check(dbr_dev_model_inst.ref_count - r0 inside {[lo:hi]}, 1);
      check(dbr_dev_model_inst.proto_err, 0);
   endtask
   task automatic t_fault();
      sref_req <= 1;
      repeat (3) @(posedge sys_clk);
      // an owed refresh is paid first, so allow one refresh sequence before self-refresh is allowed
      for (int w = 0; w < 20 && sref_ok !== 1'b1; w++) @(posedge sys_clk);
      check(sref_ok, 1);
      check(req_ready, 0);
      sref_req <= 0;
      timing_fault <= 1;
      @(posedge sys_clk);
      timing_fault <= 0;
      repeat (3) @(posedge sys_clk);
      check(need_reinit, 1);
      check(req_ready, 0);
      srst <= 1;
      @(posedge sys_clk);
      srst <= 0;
      @(posedge sys_clk);
      check(need_reinit, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 0;
      for (int i = 0; i < 4; i++) t_read(i[1] ? BL_ON_FLY : BL_FIXED8, i[0], 8'h30 + i[7:0]);
      t_write(0);
      t_write(1);
      t_refresh(0, 200, 3, 5);
      t_refresh(1, 400, 8, 17);
      t_refresh(0, 390, 0, 1);
      t_fault();
      complete_run();
   end
endmodule

// file: dbr_dev_model.sv
/* dbr_dev_model: behavioural memory device on the command and data pins.
 Assumes single data rate pins sampled at sys_clk and a locked delay loop. */
module dbr_dev_model import dbr_pkg::*; #(
   parameter int RL = 5,
   parameter int RFC = 10
) (
   input wire logic sys_clk,
   input wire logic [1:0] mode_burst_field,
   input wire logic [3:0] cmd,
   input wire logic [14:0] mem_addr,
   input wire logic [15:0] mem_dq_out,
   input wire logic mem_dq_oe,
   output logic [15:0] mem_dq_in
);
   int ref_count = 0;
   int proto_err = 0;
   int wn = 0;
   int dly = 0;
   int left = 0;
   int idx = 0;
   int since_ref = 1000;
   int since_pre = 1000;
   logic [15:0] wq [8];
   logic [7:0] base;
   initial mem_dq_in = 16'h0000;
   always @(posedge sys_clk) begin
      since_ref++;
      since_pre++;
      if (left > 0 && dly > 0) dly--;
      else if (left > 0) begin
         mem_dq_in <= {4'hD, base, idx[3:0]};
         idx++;
         left--;
      end
      // released bus toggles so a stale word is never mistaken for data
      else mem_dq_in <= ~mem_dq_in;
      if (cmd != CMD_NOP && cmd != CMD_DES && since_ref < RFC) proto_err++;
      if (cmd == CMD_REF) begin
         if (since_pre < RP_CYC) proto_err++;
         ref_count++;
         since_ref = 0;
      end
      if (cmd == CMD_PRE_ALL && mem_addr[A10_POS]) since_pre = 0;
      if (cmd == CMD_RD) begin
         left = (mode_burst_field == BL_FIXED8 || mem_addr[BURST_SEL_POS]) ? 8 : 4;
         base = mem_addr[7:0];
         dly = RL - 2;
         idx = 0;
      end
      if (cmd == CMD_WR) wn = 0;
      if (mem_dq_oe && wn < 8) begin
         wq[wn] = mem_dq_out;
         wn++;
      end
   end
endmodule

// file: dbr_pkg.sv
/*
 dbr_pkg: constants and types shared by the memory-side command controller and its buffer.
 Assumes one 200 MHz system clock; figures are picoseconds or nanoseconds converted to cycles here.
*/
package dbr_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   // refresh timing in its own units
   localparam int T_RP_PS = 13750;
   localparam int T_RFC_PS = 260000;
   localparam int T_REFI_NS = 7800;
   // least times round up, the interval rounds down
   localparam int RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFI_CYC = (T_REFI_NS * 1000) / CLK_PERIOD_PS;
   localparam int MAX_POSTPONE = 8;
   localparam int MAX_PULLIN = 8;
   localparam int BEATS_CHOP = 4;
   localparam int BEATS_FULL = 8;
   localparam int CCD_CYC = 4;
   // burst-length field of mode_register_zero
   localparam logic [1:0] BL_FIXED8 = 2'h0;
   localparam logic [1:0] BL_ON_FLY = 2'h1;
   localparam int BURST_SEL_POS = 12;
   // command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hF;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE_ALL = 4'h2;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam int A10_POS = 10;

   typedef enum logic [2:0] {
      DBR_IDLE, DBR_PRE_WAIT, DBR_RFC_WAIT, DBR_READ_WAIT, DBR_READ_DATA, DBR_WRITE_DATA, DBR_HALT
   } dbr_state_t;
endpackage
